// file: design/fpx_cfg.svh
// constants for the floating-point exception context unit
// Summary of operation
// - detected condition always sets its sticky flag
// - exception raised only when mask is one
// - hardware never clears stickies nor touches masks
// - invalid first, then dz/ov/uf, inexact last
// - illegal operand or destination means invalid
// - invalid gives quiet nan, sticky, trap only when its mask is one
// - divide by zero gives signed infinity
// - overflow when rounded exponent reaches format max
// - trapped overflow stores widened record, keeps destination
// - record: sign 81, exponent 80..64, j 63
// - untrapped overflow result chosen by rounding mode
// - underflow tested before rounding, may vanish
// - trapped underflow stores widened record, keeps destination
// - untrapped underflow denormalises, sticky only if lossy
// - gradual underflow record exponent one below
// - inexact sets sticky, rounded result, optional trap
// - peripheral inexact record keeps destination precision
// - data register is three 32-bit words
// - l, g, r, s at bits 95..92
`ifndef FPX_CFG_SVH
`define FPX_CFG_SVH
`define FPX_ADR_STATUS 8'h00
`define FPX_ADR_DATA0 8'h04
`define FPX_ADR_DATA1 8'h08
`define FPX_ADR_DATA2 8'h0c
`define FPX_ADR_RESULT0 8'h10
`define FPX_ADR_RESULT1 8'h14
`define FPX_ADR_RESULT2 8'h18
`define FPX_ADR_TRAP 8'h1c
`define FPX_ADR_BITS 8
`define FPX_BIAS 17'h03fff
`define FPX_SGL_EMAX 17'h040ff
`define FPX_SGL_EMIN 17'h03f80
`define FPX_DBL_EMAX 17'h043ff
`define FPX_DBL_EMIN 17'h03c00
`define FPX_EXT_EMAX 17'h07fff
`define FPX_EXT_EMIN 17'h00000
`define FPX_ST_INV 0
`define FPX_ST_DZ 1
`define FPX_ST_OV 2
`define FPX_ST_UF 3
`define FPX_ST_PX 4
`define FPX_MK_INV 5
`define FPX_MK_DZ 6
`define FPX_MK_OV 7
`define FPX_MK_UF 8
`define FPX_MK_PX 9
`define FPX_RC_LO 10
`define FPX_PERIPH_BIT 12
`define FPX_ST_RESET 32'h0000_0000
`endif

// file: design/fpx_pkg.sv
// types for the floating-point exception context unit
package fpx_pkg;
  typedef enum logic [1:0] {
    FPX_RND_NEAREST = 2'b00,
    FPX_RND_PLUS = 2'b01,
    FPX_RND_MINUS = 2'b10,
    FPX_RND_ZERO = 2'b11
  } fpx_round_t;
  typedef enum logic [1:0] {
    FPX_FMT_SGL = 2'b00,
    FPX_FMT_DBL = 2'b01,
    FPX_FMT_EXT = 2'b10
  } fpx_fmt_t;
  typedef enum logic [2:0] {
    FPX_EXC_NONE = 3'h0,
    FPX_EXC_INV = 3'h1,
    FPX_EXC_DZ = 3'h2,
    FPX_EXC_OV = 3'h3,
    FPX_EXC_UF = 3'h4,
    FPX_EXC_PX = 3'h5
  } fpx_exc_t;
  // one finished operation handed over by the arithmetic core
  typedef struct packed {
    logic op_illegal;
    logic dest_illegal;
    logic is_div;
    logic divisor_zero;
    logic dividend_finite_nz;
    logic to_dec_or_int;
    logic sign;
    logic [16:0] exp_rounded;
    logic [16:0] exp_unrounded;
    logic [16:0] exp_after_round;
    logic [63:0] sig;
    logic [3:0] lgrs;
    logic denorm_lossy;
    logic inexact;
    fpx_fmt_t fmt;
  } fpx_op_t;
  typedef struct packed {
    logic [4:0] flags;
    fpx_exc_t taken;
  } fpx_cls_t;
endpackage : fpx_pkg

// file: design/fpx_classify.sv
// exception detection and precedence for one operation
`timescale 1ns/1ps
`default_nettype none
`include "fpx_cfg.svh"
module fpx_classify (
  input wire fpx_pkg::fpx_op_t op,
  input wire logic [4:0] masks,
  output fpx_pkg::fpx_cls_t cls
);
  function automatic logic [16:0] fpx_emax(input fpx_pkg::fpx_fmt_t f);
    unique case (f)
      fpx_pkg::FPX_FMT_SGL: fpx_emax = `FPX_SGL_EMAX;
      fpx_pkg::FPX_FMT_DBL: fpx_emax = `FPX_DBL_EMAX;
      default: fpx_emax = `FPX_EXT_EMAX;
    endcase
  endfunction : fpx_emax
  function automatic logic [16:0] fpx_emin(input fpx_pkg::fpx_fmt_t f);
    unique case (f)
      fpx_pkg::FPX_FMT_SGL: fpx_emin = `FPX_SGL_EMIN;
      fpx_pkg::FPX_FMT_DBL: fpx_emin = `FPX_DBL_EMIN;
      default: fpx_emin = `FPX_EXT_EMIN;
    endcase
  endfunction : fpx_emin
  wire inv = op.op_illegal | op.dest_illegal;
  wire dz = op.is_div & op.divisor_zero & op.dividend_finite_nz;
  wire ov = ~inv & ~dz & ($signed(op.exp_rounded) >= $signed(fpx_emax(op.fmt)));
  // unrounded test, cleared if rounding lifts it
  wire uf_raw = ($signed(op.exp_unrounded) <= $signed(fpx_emin(op.fmt)));
  wire uf_gone = ($signed(op.exp_after_round) > $signed(fpx_emin(op.fmt)));
  // untrapped underflow flags only a lossy denormalisation
  wire uf = ~inv & ~dz & uf_raw & ~uf_gone & (masks[`FPX_ST_UF] | op.denorm_lossy);
  wire px = ~inv & op.inexact;
  wire [4:0] flags = {px, uf, ov, dz, inv};
  wire [4:0] armed = flags & masks;
  assign cls.flags = flags;
  assign cls.taken = armed[`FPX_ST_INV] ? fpx_pkg::FPX_EXC_INV :
                     armed[`FPX_ST_DZ] ? fpx_pkg::FPX_EXC_DZ :
                     armed[`FPX_ST_OV] ? fpx_pkg::FPX_EXC_OV :
                     armed[`FPX_ST_UF] ? fpx_pkg::FPX_EXC_UF :
                     armed[`FPX_ST_PX] ? fpx_pkg::FPX_EXC_PX : fpx_pkg::FPX_EXC_NONE;
endmodule : fpx_classify
`default_nettype wire

// file: design/fpx_subst.sv
// result substitution for untrapped exceptions
`timescale 1ns/1ps
`default_nettype none
`include "fpx_cfg.svh"
module fpx_subst (
  input wire fpx_pkg::fpx_op_t op,
  input wire fpx_pkg::fpx_round_t rnd,
  input wire logic inv,
  input wire logic dz,
  input wire logic ov,
  output logic [81:0] result
);
  wire [16:0] emax = (op.fmt == fpx_pkg::FPX_FMT_SGL) ? `FPX_SGL_EMAX :
                     (op.fmt == fpx_pkg::FPX_FMT_DBL) ? `FPX_DBL_EMAX : `FPX_EXT_EMAX;
  wire [16:0] emax_m1 = emax - 17'h00001;
  wire [63:0] big_sig = (op.fmt == fpx_pkg::FPX_FMT_SGL) ? 64'hffffff00_00000000 :
                        (op.fmt == fpx_pkg::FPX_FMT_DBL) ? 64'hffffffff_fffff800 :
                        64'hffffffff_ffffffff;
  wire [81:0] inf = {op.sign, emax, 64'h80000000_00000000};
  wire [81:0] big = {op.sign, emax_m1, big_sig};
  wire [81:0] qnan = {1'b0, emax, 64'hc0000000_00000000};
  wire ov_to_inf = (rnd == fpx_pkg::FPX_RND_NEAREST) |
                   ((rnd == fpx_pkg::FPX_RND_MINUS) & op.sign) |
                   ((rnd == fpx_pkg::FPX_RND_PLUS) & ~op.sign);
  assign result = inv ? qnan : dz ? inf : ov ? (ov_to_inf ? inf : big) :
                  {op.sign, op.exp_rounded, op.sig};
endmodule : fpx_subst
`default_nettype wire

// file: design/fpx_unit.sv
// exception context unit: status, data record and wishbone slave
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fpx_cfg.svh"
module fpx_unit (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`FPX_ADR_BITS-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic op_valid,
  input wire fpx_pkg::fpx_op_t op,
  output logic [81:0] dest_result,
  output logic dest_write,
  output logic trap,
  output fpx_pkg::fpx_exc_t trap_kind
);
  logic [31:0] arith_status_reg;
  logic [31:0] arith_status_next;
  logic [95:0] exception_data_reg;
  logic [95:0] exception_data_next;
  logic [81:0] dest_result_reg;
  logic dest_write_reg;
  logic trap_reg;
  fpx_pkg::fpx_exc_t trap_kind_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic st_seen_reg;
  fpx_pkg::fpx_cls_t cls;
  logic [81:0] subst;

  wire [4:0] masks = arith_status_reg[`FPX_MK_PX:`FPX_MK_INV];
  wire periph_mode = arith_status_reg[`FPX_PERIPH_BIT];
  wire fpx_pkg::fpx_round_t rnd = fpx_pkg::fpx_round_t'(arith_status_reg[`FPX_RC_LO+1:`FPX_RC_LO]);

  fpx_classify u_cls (
    .op(op),
    .masks(masks),
    .cls(cls)
  );
  fpx_subst u_sub (
    .op(op),
    .rnd(rnd),
    .inv(cls.flags[`FPX_ST_INV]),
    .dz(cls.flags[`FPX_ST_DZ]),
    .ov(cls.flags[`FPX_ST_OV] & ~masks[`FPX_ST_OV]),
    .result(subst)
  );

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire bus_wr = bus_req & wb_we_i;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire st_wr = bus_wr & (wb_adr_i == `FPX_ADR_STATUS);
  wire [2:0] dr_wr;
  assign dr_wr[0] = bus_wr & (wb_adr_i == `FPX_ADR_DATA0);
  assign dr_wr[1] = bus_wr & (wb_adr_i == `FPX_ADR_DATA1);
  assign dr_wr[2] = bus_wr & (wb_adr_i == `FPX_ADR_DATA2);
  wire [31:0] st_wval = (arith_status_reg & ~wmask) | (wb_dat_i & wmask);

  // trapped overflow or underflow keeps the destination
  wire tk_ov = cls.taken == fpx_pkg::FPX_EXC_OV;
  wire tk_uf = cls.taken == fpx_pkg::FPX_EXC_UF;
  wire tk_px = cls.taken == fpx_pkg::FPX_EXC_PX;
  wire tk_inv = cls.taken == fpx_pkg::FPX_EXC_INV;
  // gradual underflow with inexact trap gives exponent one below
  wire grad = cls.flags[`FPX_ST_UF] & ~masks[`FPX_ST_UF] & masks[`FPX_ST_PX] & (|op.sig);
  wire [16:0] rec_exp = grad ? op.exp_rounded - 17'h00001 : op.exp_rounded;
  // record layout sign, exponent, j, fraction
  wire [81:0] rec_ext = {op.sign, rec_exp, op.sig};
  // peripheral inexact: own precision, exponent sign-extended
  wire [63:0] rj_sig = (op.fmt == fpx_pkg::FPX_FMT_SGL) ? {40'h0, op.sig[63:40]} :
                       (op.fmt == fpx_pkg::FPX_FMT_DBL) ? {11'h0, op.sig[63:11]} : op.sig;
  wire [16:0] own_exp = rec_exp - `FPX_BIAS;
  wire [81:0] rec_own = {op.sign, own_exp, rj_sig};
  wire use_own = tk_px & periph_mode & (op.fmt != fpx_pkg::FPX_FMT_EXT);
  // l g r s bits on top
  wire [95:0] rec_word = {op.lgrs, 10'h000, use_own ? rec_own : rec_ext};
  // record loaded on a taken trap unless conversion leaves it unspecified
  wire rec_load = op_valid & (tk_ov | tk_uf | cls.taken == fpx_pkg::FPX_EXC_DZ |
                  tk_inv | (tk_px & ~op.to_dec_or_int));
  wire dest_we = op_valid & ~tk_ov & ~tk_uf;

  always_comb begin
    arith_status_next = st_wr ? st_wval : arith_status_reg;
    // set wins over a same-cycle software clear
    if (op_valid) begin
      arith_status_next[`FPX_ST_PX:`FPX_ST_INV] = arith_status_next[`FPX_ST_PX:`FPX_ST_INV] |
                                                  cls.flags;
    end
  end

  // three data words, written by bus or loaded by record
  always_comb begin
    exception_data_next = exception_data_reg;
    for (int i = 0; i < 3; i++) begin
      if (dr_wr[i]) begin
        exception_data_next[i*32 +: 32] = wb_dat_i;
      end
    end
    if (rec_load) begin
      exception_data_next = rec_word;
    end
  end

  wire [31:0] rd_mux = (wb_adr_i == `FPX_ADR_STATUS) ? arith_status_reg :
                       (wb_adr_i == `FPX_ADR_DATA0) ? exception_data_reg[31:0] :
                       (wb_adr_i == `FPX_ADR_DATA1) ? exception_data_reg[63:32] :
                       (wb_adr_i == `FPX_ADR_DATA2) ? exception_data_reg[95:64] :
                       (wb_adr_i == `FPX_ADR_RESULT0) ? dest_result_reg[31:0] :
                       (wb_adr_i == `FPX_ADR_RESULT1) ? dest_result_reg[63:32] :
                       (wb_adr_i == `FPX_ADR_RESULT2) ? {14'h0, dest_result_reg[81:64]} :
                       (wb_adr_i == `FPX_ADR_TRAP) ? {29'h0, trap_kind_reg} : 32'h0;

  // exception state survives reset; handshake, destination and trap outputs are reset
  always_ff @(posedge mclk) begin
    arith_status_reg <= arith_status_next;
    exception_data_reg <= exception_data_next;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      st_seen_reg <= 1'b0;
      rdata_reg <= 32'h0;
      dest_result_reg <= 82'h0;
      dest_write_reg <= 1'b0;
      trap_reg <= 1'b0;
      trap_kind_reg <= fpx_pkg::FPX_EXC_NONE;
    end else begin
      ack_reg <= bus_req;
      // status is unknown at power-up until software writes it once
      st_seen_reg <= st_seen_reg | st_wr;
      rdata_reg <= bus_req ? rd_mux : rdata_reg;
      dest_write_reg <= dest_we;
      dest_result_reg <= dest_we ? subst : dest_result_reg;
      trap_reg <= op_valid & (cls.taken != fpx_pkg::FPX_EXC_NONE);
      trap_kind_reg <= op_valid ? cls.taken : trap_kind_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign dest_result = dest_result_reg;
  assign dest_write = dest_write_reg;
  assign trap = trap_reg;
  assign trap_kind = trap_kind_reg;

  // sticky never drops without a software write
  a_sticky_hold: assert property (@(posedge mclk) disable iff (rst)
    st_seen_reg && $past(st_seen_reg) && !$past(st_wr) |->
    ((arith_status_reg[4:0] & $past(arith_status_reg[4:0])) ==
    $past(arith_status_reg[4:0]))) else $error("sticky flag cleared by hardware");
  a_mask_hold: assert property (@(posedge mclk) disable iff (rst)
    st_seen_reg && $past(st_seen_reg) && !$past(st_wr) |-> $stable(masks))
    else $error("mask changed by hardware");
  a_sticky_set: assert property (@(posedge mclk) disable iff (rst)
    op_valid |=> ((arith_status_reg[4:0] & $past(cls.flags)) == $past(cls.flags)))
    else $error("detected condition not made sticky");
  a_trap_masked: assert property (@(posedge mclk) disable iff (rst)
    op_valid && ((cls.flags & masks) == 5'h00) |=> !trap) else $error("trap while masked");
  a_trap_armed: assert property (@(posedge mclk) disable iff (rst)
    op_valid && ((cls.flags & masks) != 5'h00) |=> trap) else $error("armed trap missed");
  a_inv_first: assert property (@(posedge mclk) disable iff (rst)
    op_valid && cls.flags[0] && masks[0] |=> trap_kind == fpx_pkg::FPX_EXC_INV)
    else $error("invalid not highest");
  a_ov_keep_dest: assert property (@(posedge mclk) disable iff (rst)
    op_valid && tk_ov |=> !dest_write ##1 !dest_write || $past(dest_we))
    else $error("trapped overflow wrote destination");
  a_lgrs_place: assert property (@(posedge mclk) disable iff (rst)
    rec_load && !(|dr_wr) |=> exception_data_reg[95:92] == $past(op.lgrs))
    else $error("lgrs bits misplaced");
endmodule : fpx_unit
`default_nettype wire

// file: test/fpx_host_model.sv
// host model: wishbone master and context save and restore sequences
`timescale 1ns/1ps
`default_nettype none
`include "fpx_cfg.svh"
module fpx_host_model (
  input wire logic mclk,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [`FPX_ADR_BITS-1:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i,
  output logic hang
);
  initial begin
    wb_cyc_o = 1'h0;
    wb_stb_o = 1'h0;
    wb_we_o = 1'h0;
    wb_adr_o = '0;
    wb_sel_o = 4'hf;
    wb_dat_o = 32'h0;
    hang = 1'h0;
  end
  // one classic cycle, held until ack is sampled high or 64 clocks pass
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output logic [31:0] rdat);
    int n;
    @(posedge mclk);
    wb_cyc_o <= 1'h1;
    wb_stb_o <= 1'h1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_dat_o <= dat;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_i !== 1'h1 && n < 64);
    rdat = wb_dat_i;
    if (wb_ack_i !== 1'h1) hang <= 1'h1;
    wb_cyc_o <= 1'h0;
    wb_stb_o <= 1'h0;
    wb_we_o <= 1'h0;
    wb_dat_o <= ~dat;
  endtask : wb_cycle
  // status kept, cleared, then data words
  task automatic save_ctx(output logic [31:0] st, output logic [95:0] dr);
    logic [31:0] d;
    wb_cycle(1'h0, `FPX_ADR_STATUS, 32'h0, st);
    wb_cycle(1'h1, `FPX_ADR_STATUS, 32'h0, d);
    wb_cycle(1'h0, `FPX_ADR_DATA0, 32'h0, dr[31:0]);
    wb_cycle(1'h0, `FPX_ADR_DATA1, 32'h0, dr[63:32]);
    wb_cycle(1'h0, `FPX_ADR_DATA2, 32'h0, dr[95:64]);
  endtask : save_ctx
  // clear, reload data words, status last
  task automatic restore_ctx(input logic [31:0] st, input logic [95:0] dr);
    logic [31:0] d;
    wb_cycle(1'h1, `FPX_ADR_STATUS, 32'h0, d);
    wb_cycle(1'h1, `FPX_ADR_DATA0, dr[31:0], d);
    wb_cycle(1'h1, `FPX_ADR_DATA1, dr[63:32], d);
    wb_cycle(1'h1, `FPX_ADR_DATA2, dr[95:64], d);
    wb_cycle(1'h1, `FPX_ADR_STATUS, st, d);
  endtask : restore_ctx
endmodule : fpx_host_model
`default_nettype wire

// file: test/test_fpx_unit.sv
// self-checking bench for the exception context unit
`timescale 1ns/1ps
`default_nettype none
`include "fpx_cfg.svh"
module test_fpx_unit;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic cyc, stb, we, ack, hang, op_valid, dest_write, trap;
  logic [`FPX_ADR_BITS-1:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  logic [81:0] dest_result;
  fpx_pkg::fpx_op_t op = '0;
  fpx_pkg::fpx_exc_t trap_kind;
  int errors = 0;
  int checks_done = 0;
  always #2.5 mclk = ~mclk;
  initial op_valid = 1'h0;
  fpx_host_model u_host (.mclk(mclk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dat_w), .wb_dat_i(dat_r), .wb_ack_i(ack),
    .hang(hang));
  fpx_unit u_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .op_valid(op_valid), .op(op), .dest_result(dest_result), .dest_write(dest_write),
    .trap(trap), .trap_kind(trap_kind));
  task automatic complete_run();
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [95:0] seen, input logic [95:0] expd);
    checks_done++;
    if (seen !== expd) begin
      errors++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, expd);
    end
  endtask : check
  always @(posedge hang) begin
    errors++;
    complete_run();
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_host.wb_cycle(1'h1, a, d, x);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] expd);
    logic [31:0] x;
    u_host.wb_cycle(1'h0, a, 32'h0, x);
    check(x, expd);
  endtask : rd_chk
  function automatic fpx_pkg::fpx_op_t blank();
    blank = '0;
    blank.fmt = fpx_pkg::FPX_FMT_EXT;
    blank.exp_rounded = `FPX_BIAS;
    blank.exp_unrounded = `FPX_BIAS;
    blank.exp_after_round = `FPX_BIAS;
  endfunction : blank
  task automatic send_op(input fpx_pkg::fpx_op_t o);
    @(posedge mclk);
    op_valid <= 1'h1;
    op <= o;
    @(posedge mclk);
    op_valid <= 1'h0;
    @(negedge mclk);
  endtask : send_op
  task automatic t_masked();
    fpx_pkg::fpx_op_t o;
    o = blank();
    o.inexact = 1'h1;
    wr(`FPX_ADR_STATUS, 32'h0);
    send_op(o);
    check(trap, 1'h0);
    rd_chk(`FPX_ADR_STATUS, 32'h10);
    send_op(blank());
    rd_chk(`FPX_ADR_STATUS, 32'h10);
  endtask : t_masked
  task automatic t_precedence();
    fpx_pkg::fpx_op_t o;
    o = blank();
    o.op_illegal = 1'h1;
    o.is_div = 1'h1;
    o.divisor_zero = 1'h1;
    o.dividend_finite_nz = 1'h1;
    o.inexact = 1'h1;
    wr(`FPX_ADR_STATUS, 32'h3e0);
    send_op(o);
    check(trap, 1'h1);
    check(trap_kind, fpx_pkg::FPX_EXC_INV);
    rd_chk(`FPX_ADR_STATUS, 32'h3e3);
    o = blank();
    o.dest_illegal = 1'h1;
    send_op(o);
    check(trap_kind, fpx_pkg::FPX_EXC_INV);
    rd_chk(`FPX_ADR_TRAP, 32'h1);
    o = blank();
    o.is_div = 1'h1;
    o.divisor_zero = 1'h1;
    o.dividend_finite_nz = 1'h1;
    o.sign = 1'h1;
    wr(`FPX_ADR_STATUS, 32'h0);
    send_op(o);
    check({trap, dest_write, dest_result[81:64]}, {1'h0, 1'h1, 1'h1, `FPX_EXT_EMAX});
    rd_chk(`FPX_ADR_STATUS, 32'h2);
  endtask : t_precedence
  task automatic t_ov_trap();
    fpx_pkg::fpx_op_t o;
    o = blank();
    o.sign = 1'h1;
    o.exp_rounded = 17'h08001;
    o.sig = 64'hc000_0000_0000_0123;
    o.lgrs = 4'ha;
    o.inexact = 1'h1;
    wr(`FPX_ADR_STATUS, 32'h2a0);
    send_op(o);
    check({trap, dest_write}, 2'h2);
    check(trap_kind, fpx_pkg::FPX_EXC_OV);
    rd_chk(`FPX_ADR_STATUS, 32'h2b4);
    rd_chk(`FPX_ADR_DATA0, 32'h0000_0123);
    rd_chk(`FPX_ADR_DATA1, 32'hc000_0000);
    rd_chk(`FPX_ADR_DATA2, {4'ha, 10'h0, 1'h1, 17'h08001});
  endtask : t_ov_trap
  task automatic t_ov_modes();
    fpx_pkg::fpx_op_t o;
    logic s, inf;
    fpx_pkg::fpx_round_t r;
    for (int i = 0; i < 8; i++) begin
      r = fpx_pkg::fpx_round_t'(i[1:0]);
      s = i[2];
      inf = r == fpx_pkg::FPX_RND_NEAREST || (r == fpx_pkg::FPX_RND_PLUS && !s) ||
            (r == fpx_pkg::FPX_RND_MINUS && s);
      o = blank();
      o.sign = s;
      o.exp_rounded = `FPX_EXT_EMAX;
      wr(`FPX_ADR_STATUS, {20'h0, r, 10'h0});
      send_op(o);
      check({trap, dest_write}, 2'h1);
      check(dest_result[81], s);
      check(dest_result[80:64], inf ? `FPX_EXT_EMAX : 17'h07ffe);
    end
  endtask : t_ov_modes
  task automatic t_underflow();
    fpx_pkg::fpx_op_t o;
    o = blank();
    o.fmt = fpx_pkg::FPX_FMT_SGL;
    o.exp_unrounded = `FPX_SGL_EMIN;
    o.exp_rounded = `FPX_SGL_EMIN;
    o.exp_after_round = `FPX_SGL_EMIN;
    wr(`FPX_ADR_STATUS, 32'h0);
    send_op(o);
    rd_chk(`FPX_ADR_STATUS, 32'h0);
    o.denorm_lossy = 1'h1;
    send_op(o);
    check(trap, 1'h0);
    rd_chk(`FPX_ADR_STATUS, 32'h8);
  endtask : t_underflow
  task automatic t_context();
    logic [31:0] st;
    logic [95:0] dr;
    u_host.restore_ctx(32'h0000_0c3e, 96'h9abc_def0_1234_5678_0fed_cba9);
    u_host.save_ctx(st, dr);
    check(st, 32'h0000_0c3e);
    check(dr, 96'h9abc_def0_1234_5678_0fed_cba9);
    rd_chk(`FPX_ADR_STATUS, 32'h0);
    wr(8'h40, 32'h5555_aaaa);
    rd_chk(8'h40, 32'h0);
  endtask : t_context
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    t_masked();
    t_precedence();
    t_ov_trap();
    t_ov_modes();
    t_underflow();
    t_context();
    complete_run();
  end
endmodule : test_fpx_unit
`default_nettype wire
